// *** src/fpes_cmd_seq.sv ***
// Instruction sequence decoder of the flash device end.
// Assumes one write strobe per cycle at most; emits one-cycle go pulses.
`timescale 1ns/1ps
`include "fpes_defines.svh"
module fpes_cmd_seq (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Write strobe and state of the algorithm
   input  wire logic       wr,
   input  wire logic [7:0] wdata,
   input  wire logic       win,
   input  wire logic       busy,
   // Decoded instructions
   output logic            go_prog,
   output logic            go_sect,
   output logic            go_bulk,
   output logic            go_rst
);
   fpes_pkg::fpes_cmd_t q_reg;
   fpes_pkg::fpes_cmd_t q_next;

   // Steps 0..3 program, 4..6 erase; reset is accepted at any step
   always_comb begin
      q_next  = q_reg;
      go_prog = 1'b0;
      go_sect = 1'b0;
      go_bulk = 1'b0;
      go_rst  = 1'b0;
      if (wr) begin
         q_next.step = 3'h0;
         if (wdata == `FPES_CMD_RESET) begin
            go_rst = 1'b1; // R19
         end else if (win) begin
            go_sect = (wdata == `FPES_CMD_SECT); // R02
         end else if (!busy) begin
            case (q_reg.step)
               3'h0, 3'h4: q_next.step = (wdata == `FPES_CMD_UNLK1) ? q_reg.step + 3'h1 : 3'h0;
               3'h1, 3'h5: q_next.step = (wdata == `FPES_CMD_UNLK2) ? q_reg.step + 3'h1 : 3'h0;
               3'h2: q_next.step = (wdata == `FPES_CMD_PROG) ? 3'h3 : (wdata == `FPES_CMD_ERASE) ? 3'h4 : 3'h0;
               3'h3: go_prog = 1'b1; // R05
               3'h6: begin
                  go_sect = (wdata == `FPES_CMD_SECT); // R03
                  go_bulk = (wdata == `FPES_CMD_BULK); // R03
               end
               default: q_next.step = 3'h0;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end
endmodule : fpes_cmd_seq

// *** src/fpes_defines.svh ***
// Flash status block constants: offsets, fields, counts.
// Assumes a 25 MHz clock; included by the package and the three src module files.
`ifndef FPES_DEFINES_SVH
`define FPES_DEFINES_SVH
`define FPES_CLK_MHZ   25
`define FPES_WIN_US    100
`define FPES_WIN_CYC   (`FPES_WIN_US * `FPES_CLK_MHZ)
`define FPES_PROG_CYC  16
`define FPES_ERASE_CYC 32
`define FPES_CMD_UNLK1 8'hAA
`define FPES_CMD_UNLK2 8'h55
`define FPES_CMD_PROG  8'hA0
`define FPES_CMD_ERASE 8'h80
`define FPES_CMD_SECT  8'h30
`define FPES_CMD_BULK  8'h10
`define FPES_CMD_RESET 8'hF0
`define FPES_ERASED    8'hFF
`define FPES_BIT_POLL  7
`define FPES_BIT_TOG   6
`define FPES_BIT_ERR   5
`define FPES_BIT_WIN   3
`define FPES_SECT_MSB  7
`define FPES_SECT_LSB  6
`define FPES_REG_CTRL  8'h00
`define FPES_REG_ADDR  8'h04
`define FPES_REG_DATA  8'h08
`define FPES_REG_STAT  8'h0C
`define FPES_AXI_OKAY  2'h0
`define FPES_AXI_SLV   2'h2
`endif

// *** src/fpes_dev.sv ***
// Flash device end: byte program and sector/bulk erase with status reads.
// Assumes the host keeps to the instruction sequences and polls for completion.
// Summary of operation
// R01 - Timer bit low 100 us after sector erase
// R02 - Timer bit high on expiry or added erase
// R03 - Bulk or sector erase, never byte erase
// R04 - Erased reads FF, programming clears bits only
// R05 - Program one byte per operation
// R06 - Host erases before programming
// R07 - Host starts operations by instruction sequence
// R08 - Completion shown by poll, toggle, ready pin
// R09 - Host polls the programmed address
// R10 - Busy program reads inverted bit 7
// R11 - Done when bit 7 true, error low
// R12 - Host rereads poll bit after error
// R13 - Error on timeout or zero-to-one write
// R14 - Host verifies programmed byte afterwards
// R15 - Poll bit reads zero during erase
// R16 - Error high on erase timeout only
// R17 - Erase status on reads in sector
// R18 - Toggle bit flips per read while busy
// R19 - Error cleared only by reset instruction
// R20 - Status valid after fourth or sixth write
// R21 - Ready pin busy exactly during algorithm
`timescale 1ns/1ps
`include "fpes_defines.svh"
module fpes_dev (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Link toward the host
   fpes_link_if.dev  link,
   // Fault injection: makes the running algorithm time out
   input  wire logic fail_inject,
   // Error flag copy for the user side
   output logic      err_out
);
   fpes_pkg::fpes_dev_t q_reg;
   fpes_pkg::fpes_dev_t q_next;
   logic [7:0] mem [0:255];
   logic       go_prog;
   logic       go_sect;
   logic       go_bulk;
   logic       go_rst;
   logic       wr_sel;
   logic       rd_sel;
   logic       busy;
   logic       mem_prog;
   logic       mem_erase;
   logic [7:0] status;
   logic [3:0] hit;

   // One-hot sector of an address
   function automatic logic [3:0] sect_of(input logic [7:0] a);
      sect_of = 4'h1 << a[`FPES_SECT_MSB:`FPES_SECT_LSB];
   endfunction : sect_of

   assign wr_sel = link.wr & link.main_flash_sector_select;
   assign rd_sel = link.rd & link.main_flash_sector_select;
   assign busy   = (q_reg.st != fpes_pkg::DS_IDLE) && (q_reg.st != fpes_pkg::DS_FAIL);
   assign hit    = sect_of(link.addr);

   // Instruction decoding lives in its own small block
   fpes_cmd_seq u_cmd (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr      (wr_sel),
      .wdata   (link.wdata),
      .win     (q_reg.st == fpes_pkg::DS_WIN),
      .busy    (busy),
      .go_prog (go_prog),
      .go_sect (go_sect),
      .go_bulk (go_bulk),
      .go_rst  (go_rst)
   );

   // Status byte; undefined bits read as zero
   always_comb begin
      status = 8'h00;
      status[`FPES_BIT_POLL] = q_reg.is_prog ? ~q_reg.tdat[7] : 1'b0; // R10 R15
      status[`FPES_BIT_TOG]  = ~q_reg.tog; // R18
      status[`FPES_BIT_ERR]  = q_reg.err; // R13 R16
      status[`FPES_BIT_WIN]  = !q_reg.is_prog && (q_reg.st != fpes_pkg::DS_WIN); // R01 R02
   end

   // Algorithm sequencing, status reads and the ready pin
   always_comb begin
      q_next      = q_reg;
      q_next.rvld = 1'b0;
      mem_prog    = 1'b0;
      mem_erase   = 1'b0;
      case (q_reg.st)
         fpes_pkg::DS_IDLE: begin
            q_next.cnt = 12'h000;
            if (go_prog) begin
               q_next.st      = fpes_pkg::DS_PROG; // R20
               q_next.is_prog = 1'b1;
               q_next.tgt     = link.addr;
               q_next.tdat    = link.wdata;
               q_next.bad     = |(link.wdata & ~mem[link.addr]); // R13
               q_next.err     = 1'b0;
            end else if (go_sect) begin
               q_next.st      = fpes_pkg::DS_WIN; // R01
               q_next.is_prog = 1'b0;
               q_next.sect    = hit;
               q_next.err     = 1'b0;
            end else if (go_bulk) begin
               q_next.st      = fpes_pkg::DS_ERASE; // R03
               q_next.is_prog = 1'b0;
               q_next.sect    = 4'hF;
               q_next.err     = 1'b0;
            end
         end
         fpes_pkg::DS_PROG: begin
            q_next.cnt = q_reg.cnt + 12'h001;
            if (q_reg.cnt == 12'(`FPES_PROG_CYC - 1)) begin
               if (q_reg.bad || fail_inject) begin
                  q_next.err = 1'b1; // R13
                  q_next.st  = fpes_pkg::DS_FAIL;
               end else begin
                  mem_prog  = 1'b1;
                  q_next.st = fpes_pkg::DS_IDLE; // R11
               end
            end
         end
         fpes_pkg::DS_WIN: begin
            q_next.cnt = q_reg.cnt + 12'h001;
            if (go_sect) begin
               q_next.sect = q_reg.sect | hit; // R02
               q_next.st   = fpes_pkg::DS_ERASE;
               q_next.cnt  = 12'h000;
            end else if (q_reg.cnt == 12'(`FPES_WIN_CYC - 1)) begin
               q_next.st  = fpes_pkg::DS_ERASE; // R01 R02
               q_next.cnt = 12'h000;
            end
         end
         fpes_pkg::DS_ERASE: begin
            q_next.cnt = q_reg.cnt + 12'h001;
            if (q_reg.cnt == 12'(`FPES_ERASE_CYC - 1)) begin
               if (fail_inject) begin
                  q_next.err = 1'b1; // R16
                  q_next.st  = fpes_pkg::DS_FAIL;
               end else begin
                  mem_erase = 1'b1;
                  q_next.st = fpes_pkg::DS_IDLE; // R15
               end
            end
         end
         fpes_pkg::DS_FAIL: q_next.cnt = 12'h000; // Held until reset instruction
         default: q_next.st = fpes_pkg::DS_IDLE;
      endcase
      // Reset instruction aborts anything and clears the error
      if (go_rst) begin
         q_next.st  = fpes_pkg::DS_IDLE;
         q_next.err = 1'b0; // R19
         q_next.cnt = 12'h000;
      end
      // Reads: array when idle, status while an algorithm runs or failed
      if (rd_sel) begin
         q_next.rvld = 1'b1;
         if (q_reg.st == fpes_pkg::DS_IDLE) begin
            q_next.rdata = mem[link.addr]; // R04 R11
         end else begin
            q_next.rdata = status; // R08 R17
            q_next.tog   = q_reg.tog ^ busy; // R18
         end
      end
      q_next.rdyb    = (q_next.st == fpes_pkg::DS_IDLE) || (q_next.st == fpes_pkg::DS_FAIL); // R21
      q_next.err_out = q_next.err;
   end

   // Control state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_reg      <= '0;
         q_reg.rdyb <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   // Array cells; no reset, contents are data rather than control
   always_ff @(posedge clk) begin
      if (mem_prog) begin
         mem[q_reg.tgt] <= mem[q_reg.tgt] & q_reg.tdat; // R04 R05
      end
      for (int i = 0; i < 256; i++) begin
         if (mem_erase && q_reg.sect[i / 64]) begin
            mem[i] <= `FPES_ERASED; // R03 R04
         end
      end
   end

   assign link.rdata      = q_reg.rdata;
   assign link.rvld       = q_reg.rvld;
   assign link.rdy_busy_n = q_reg.rdyb; // R08
   assign err_out         = q_reg.err_out;
endmodule : fpes_dev

// *** src/fpes_host.sv ***
// Controller end: AXI4-Lite registers, instruction issue and status polling.
// Assumes the device answers every read with a one-cycle valid.
`timescale 1ns/1ps
`include "fpes_defines.svh"
module fpes_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Link toward the device
   fpes_link_if.host        link,
   // AXI4-Lite write channels
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   fpes_pkg::fpes_host_t q_reg;
   fpes_pkg::fpes_host_t q_next;
   logic [2:0]           len;
   logic                 exp7;

   // Byte of step i of an instruction sequence
   function automatic logic [7:0] seq_byte(input fpes_pkg::fpes_op_t op, input logic [2:0] i,
                                           input logic [7:0] d);
      case (i)
         3'h0: seq_byte = (op == fpes_pkg::OP_RESET) ? `FPES_CMD_RESET : `FPES_CMD_UNLK1;
         3'h1, 3'h4: seq_byte = `FPES_CMD_UNLK2;
         3'h2: seq_byte = (op == fpes_pkg::OP_PROG) ? `FPES_CMD_PROG : `FPES_CMD_ERASE;
         3'h3: seq_byte = (op == fpes_pkg::OP_PROG) ? d : `FPES_CMD_UNLK1;
         default: seq_byte = (op == fpes_pkg::OP_BULK) ? `FPES_CMD_BULK : `FPES_CMD_SECT;
      endcase
   endfunction : seq_byte

   assign len  = (q_reg.op == fpes_pkg::OP_PROG) ? 3'h4 : (q_reg.op == fpes_pkg::OP_RESET) ? 3'h1 : 3'h6;
   assign exp7 = (q_reg.op == fpes_pkg::OP_PROG) ? q_reg.dat[7] : 1'b1;

   // Register slave and link engine
   always_comb begin
      q_next        = q_reg;
      q_next.wr     = 1'b0;
      q_next.rd     = 1'b0;
      q_next.sel    = 1'b0;
      // Write address and data are taken in either order
      if (s_axi_awvalid && q_reg.awready) begin
         q_next.aw_have = 1'b1;
         q_next.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && q_reg.wready) begin
         q_next.w_have = 1'b1;
         q_next.wdata  = s_axi_wdata;
      end
      if (q_reg.aw_have && q_reg.w_have && !q_reg.bvalid) begin
         q_next.bvalid  = 1'b1;
         q_next.bresp   = `FPES_AXI_OKAY;
         q_next.aw_have = 1'b0;
         q_next.w_have  = 1'b0;
         case (q_reg.awaddr)
            `FPES_REG_CTRL: begin
               if (!q_reg.busy && s_axi_wstrb[0]) begin
                  q_next.op    = fpes_pkg::fpes_op_t'(q_reg.wdata[2:0]);
                  q_next.busy  = 1'b1;
                  q_next.done  = 1'b0;
                  q_next.fail  = 1'b0;
                  q_next.idx   = 3'h0;
                  q_next.rechk = 1'b0;
                  q_next.ver   = 1'b0;
                  q_next.st    = (q_reg.wdata[2:0] == 3'h0) ? fpes_pkg::HS_RD : fpes_pkg::HS_SEQ; // R07
               end
            end
            `FPES_REG_ADDR: q_next.adr = q_reg.wdata[7:0];
            `FPES_REG_DATA: q_next.dat = q_reg.wdata[7:0];
            `FPES_REG_STAT: q_next.bresp = `FPES_AXI_OKAY;
            default: q_next.bresp = `FPES_AXI_SLV;
         endcase
      end
      if (q_reg.bvalid && s_axi_bready) q_next.bvalid = 1'b0;
      q_next.awready = !q_next.aw_have && !q_next.bvalid;
      q_next.wready  = !q_next.w_have && !q_next.bvalid;
      // Reads answer one cycle after the address is taken
      if (s_axi_arvalid && q_reg.arready) begin
         q_next.rvalid = 1'b1;
         q_next.rresp  = `FPES_AXI_OKAY;
         case (s_axi_araddr)
            `FPES_REG_CTRL: q_next.rdata = 32'(q_reg.op);
            `FPES_REG_ADDR: q_next.rdata = 32'(q_reg.adr);
            `FPES_REG_DATA: q_next.rdata = 32'(q_reg.dat);
            `FPES_REG_STAT: q_next.rdata = {16'h0000, q_reg.rddat, 4'h0, link.rdy_busy_n, q_reg.fail,
                                            q_reg.done, q_reg.busy};
            default: begin
               q_next.rdata = 32'h0000_0000;
               q_next.rresp = `FPES_AXI_SLV;
            end
         endcase
      end
      if (q_reg.rvalid && s_axi_rready) q_next.rvalid = 1'b0;
      q_next.arready = !q_next.rvalid;
      // Link engine
      case (q_reg.st)
         fpes_pkg::HS_IDLE: q_next.idx = 3'h0;
         fpes_pkg::HS_SEQ: begin
            q_next.sel    = 1'b1;
            q_next.wr     = 1'b1;
            q_next.laddr  = q_reg.adr;
            q_next.lwdata = seq_byte(q_reg.op, q_reg.idx, q_reg.dat);
            q_next.idx    = q_reg.idx + 3'h1;
            if (q_reg.idx == len - 3'h1) begin
               q_next.st = (q_reg.op == fpes_pkg::OP_RESET) ? fpes_pkg::HS_IDLE : fpes_pkg::HS_RD; // R08
               if (q_reg.op == fpes_pkg::OP_RESET) begin
                  q_next.busy = 1'b0;
                  q_next.done = 1'b1;
               end
            end
         end
         fpes_pkg::HS_RD: begin
            q_next.sel   = 1'b1;
            q_next.rd    = 1'b1;
            q_next.laddr = q_reg.adr; // R09
            q_next.st    = fpes_pkg::HS_WT;
         end
         fpes_pkg::HS_WT: begin
            if (link.rvld) begin
               q_next.st    = fpes_pkg::HS_RD;
               q_next.rddat = link.rdata;
               if (q_reg.op == fpes_pkg::OP_READ || q_reg.ver) begin
                  q_next.fail = q_reg.ver && (link.rdata != q_reg.dat); // R14
                  q_next.done = 1'b1;
                  q_next.busy = 1'b0;
                  q_next.st   = fpes_pkg::HS_IDLE;
               end else if (link.rdata[`FPES_BIT_POLL] == exp7) begin
                  q_next.ver  = (q_reg.op == fpes_pkg::OP_PROG); // R11 R14
                  q_next.done = (q_reg.op != fpes_pkg::OP_PROG);
                  q_next.busy = (q_reg.op == fpes_pkg::OP_PROG);
                  q_next.st   = (q_reg.op == fpes_pkg::OP_PROG) ? fpes_pkg::HS_RD : fpes_pkg::HS_IDLE;
               end else if (link.rdata[`FPES_BIT_ERR]) begin
                  q_next.rechk = 1'b1; // R12
                  if (q_reg.rechk) begin
                     q_next.fail = 1'b1;
                     q_next.done = 1'b1;
                     q_next.busy = 1'b0;
                     q_next.st   = fpes_pkg::HS_IDLE;
                  end
               end
            end
         end
         default: q_next.st = fpes_pkg::HS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign link.main_flash_sector_select = q_reg.sel;
   assign link.wr     = q_reg.wr;
   assign link.rd     = q_reg.rd;
   assign link.addr   = q_reg.laddr;
   assign link.wdata  = q_reg.lwdata;
   assign s_axi_awready = q_reg.awready;
   assign s_axi_wready  = q_reg.wready;
   assign s_axi_bvalid  = q_reg.bvalid;
   assign s_axi_bresp   = q_reg.bresp;
   assign s_axi_arready = q_reg.arready;
   assign s_axi_rvalid  = q_reg.rvalid;
   assign s_axi_rdata   = q_reg.rdata;
   assign s_axi_rresp   = q_reg.rresp;
endmodule : fpes_host

// *** src/fpes_link_if.sv ***
// Link between the flash device end and its controller end.
// Assumes one shared clock; host drives strobes, device answers.
`timescale 1ns/1ps
interface fpes_link_if (input wire logic clk);
   logic       main_flash_sector_select;
   logic       wr;
   logic       rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rvld;
   logic       rdy_busy_n;
   modport host (output main_flash_sector_select, wr, rd, addr, wdata, input rdata, rvld, rdy_busy_n);
   modport dev (input main_flash_sector_select, wr, rd, addr, wdata, output rdata, rvld, rdy_busy_n);
endinterface : fpes_link_if

// *** src/fpes_pkg.sv ***
// Types of both ends of the flash status link, each type used by one end only.
// Assumes the defines header for field positions.
`include "fpes_defines.svh"
package fpes_pkg;
   typedef enum logic [2:0] {OP_READ, OP_PROG, OP_SECT, OP_BULK, OP_RESET} fpes_op_t;
   typedef enum logic [2:0] {DS_IDLE, DS_PROG, DS_WIN, DS_ERASE, DS_FAIL} fpes_dst_t;
   typedef enum logic [2:0] {HS_IDLE, HS_SEQ, HS_RD, HS_WT} fpes_hst_t;
   typedef struct packed {
      logic [2:0] step;
   } fpes_cmd_t;
   typedef struct packed {
      fpes_dst_t  st;
      logic [11:0] cnt;
      logic [7:0] tgt;
      logic [7:0] tdat;
      logic [3:0] sect;
      logic       is_prog;
      logic       bad;
      logic       err;
      logic       tog;
      logic [7:0] rdata;
      logic       rvld;
      logic       rdyb;
      logic       err_out;
   } fpes_dev_t;
   typedef struct packed {
      fpes_hst_t  st;
      fpes_op_t   op;
      logic [7:0] adr;
      logic [7:0] dat;
      logic [2:0] idx;
      logic       rechk;
      logic       ver;
      logic       busy;
      logic       done;
      logic       fail;
      logic [7:0] rddat;
      logic       sel;
      logic       wr;
      logic       rd;
      logic [7:0] laddr;
      logic [7:0] lwdata;
      logic       aw_have;
      logic       w_have;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fpes_host_t;
endpackage : fpes_pkg

// *** verif/fpes_link_assertions.sv ***
// Checker of the link between the flash device end and the controller end.
// Assumes one clock; sees only the link signals.
`timescale 1ns/1ps
module fpes_link_assertions (
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Link signals
   input wire logic       main_flash_sector_select,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rvld,
   input wire logic       rdy_busy_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [23:0] hist_reg;
   logic [1:0]  mode_reg;
   logic        pd7_reg;
   logic        tog_reg;
   logic        tv_reg;
   logic        rb_d_reg;
   // Starts from the last three bytes written
   wire prog_hit = wr && hist_reg == 24'haa55_a0;
   wire bulk_hit = wr && wdata == 8'h10 && hist_reg == 24'h80aa_55;
   // Read taken while the algorithm ran
   wire st_rd    = rvld && !rb_d_reg;
   // Mode clears once ready shows
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hist_reg <= '0;
         mode_reg <= 2'h0;
         pd7_reg  <= 1'b0;
         tog_reg  <= 1'b0;
         tv_reg   <= 1'b0;
         rb_d_reg <= 1'b1;
      end else begin
         rb_d_reg <= rdy_busy_n;
         if (wr) hist_reg <= {hist_reg[15:0], wdata};
         if (prog_hit) mode_reg <= 2'h1;
         else if (bulk_hit) mode_reg <= 2'h2;
         else if (rdy_busy_n) mode_reg <= 2'h0;
         if (prog_hit) pd7_reg <= wdata[7];
         if (rdy_busy_n) tv_reg <= 1'b0;
         else if (st_rd) tv_reg <= 1'b1;
         if (st_rd) tog_reg <= rdata[6];
      end
   end
   sequence s_running;
      !rdy_busy_n [*8];
   endsequence
   property p_rvld_after_rd;
      rd |=> rvld;
   endproperty
   property p_rvld_cause;
      rvld |-> $past(rd);
   endproperty
   property p_prog_end;
      prog_hit |-> ##[1:20] rdy_busy_n;
   endproperty
   property p_bulk_run;
      bulk_hit |=> s_running ##[20:32] rdy_busy_n;
   endproperty
   property p_prog_poll;
      st_rd && mode_reg == 2'h1 |-> rdata[7] == !pd7_reg;
   endproperty
   property p_erase_poll;
      st_rd && mode_reg == 2'h2 |-> !rdata[7] && !rdata[5] && rdata[3];
   endproperty
   property p_toggle;
      st_rd && tv_reg |-> rdata[6] != tog_reg;
   endproperty
   property p_sel_strobe;
      wr || rd |-> main_flash_sector_select;
   endproperty
   a_rvld_after_rd: assert property (p_rvld_after_rd) else $error("no answer");
   a_rvld_cause: assert property (p_rvld_cause) else $error("stray answer");
   a_prog_end: assert property (p_prog_end) else $error("program hang");
   a_bulk_run: assert property (p_bulk_run) else $error("bulk busy time");
   a_prog_poll: assert property (p_prog_poll) else $error("poll bit");
   a_erase_poll: assert property (p_erase_poll) else $error("erase status");
   a_toggle: assert property (p_toggle) else $error("no toggle");
   a_sel_strobe: assert property (p_sel_strobe) else $error("no select");
endmodule : fpes_link_assertions

// *** verif/tb_top.sv ***
// Bench: both flash ends joined by the link, driven over AXI4-Lite.
// Assumes a 25 MHz clock and the controller's register map.
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        fail_inject = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, err_out;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, s, seed;
   logic [67:0] note;
   logic [67:0] note_q[$];
   logic [7:0]  a, d;
   int          failures = 0;
   int          checked = 0;
   always #20 clk = ~clk;
   fpes_link_if link (.clk(clk));
   fpes_dev fpes_dev_i (.clk(clk), .sys_rst(sys_rst), .link(link), .fail_inject(fail_inject), .err_out(err_out));
   fpes_host fpes_host_i (.clk(clk), .sys_rst(sys_rst), .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   fpes_link_assertions fpes_link_assertions_i (.clk(clk), .sys_rst(sys_rst),
      .main_flash_sector_select(link.main_flash_sector_select), .wr(link.wr), .rd(link.rd),
      .wdata(link.wdata), .rdata(link.rdata), .rvld(link.rvld), .rdy_busy_n(link.rdy_busy_n));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic summarize();
      $display("Mismatches %0d, comparisons %0d", failures, checked);
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Read answers against the oldest note; zero mask is a bare poll
   always @(posedge clk) begin
      if (rvalid && rready && note_q.size() > 0) begin
         note = note_q.pop_front();
         if (note[67:34] != '0) cmp({rresp, rdata} & note[67:34], note[33:0]);
      end
   end
   // Address and data offered together, each released once taken
   task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
      @(posedge clk);
      awaddr  <= ad;
      wdata   <= dt;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            cmp(34'(bresp), 34'(er));
            return;
         end
      end
      failures++;
      summarize();
   endtask : axw
   task automatic axr(input logic [7:0] ad, input logic [33:0] m, input logic [33:0] e, output logic [31:0] q);
      @(posedge clk);
      note_q.push_back({m, e});
      araddr  <= ad;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            q = rdata;
            rready <= 1'b0;
            return;
         end
      end
      failures++;
      summarize();
   endtask : axr
   // Bounded poll; the sector window alone is 2500 cycles
   task automatic wait_idle();
      logic [31:0] st;
      for (int n = 0; n < 1500; n++) begin
         axr(8'h0c, '0, '0, st);
         if (st[0] === 1'b0) return;
      end
      failures++;
      summarize();
   endtask : wait_idle
   task automatic op(input logic [2:0] c);
      axw(8'h00, 32'(c), 2'h0);
      wait_idle();
   endtask : op
   task automatic chk(input logic [31:0] m, input logic [31:0] e);
      axr(8'h0c, {2'b11, m}, {2'b00, e}, s);
   endtask : chk
   // Erase, program, refused write, timeout, sector erase, bad address
   initial begin
      seed = lfsr(32'hca93);
      a = {2'b01, seed[5:0]};
      d = {seed[15:9], 1'b0};
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      op(3'h3);
      chk(32'h0000_0007, 32'h0000_0002);
      axw(8'h04, 32'(a), 2'h0);
      axw(8'h08, 32'(d), 2'h0);
      op(3'h1);
      chk(32'h0000_0007, 32'h0000_0002);
      op(3'h0);
      chk(32'h0000_ff00, {16'h0000, d, 8'h00});
      axw(8'h08, 32'(d | 8'h01), 2'h0);
      op(3'h1);
      chk(32'h0000_0004, 32'h0000_0004);
      cmp(34'(err_out), 34'h1);
      op(3'h4);
      cmp(34'(err_out), 34'h0);
      op(3'h0);
      chk(32'h0000_ff00, {16'h0000, d, 8'h00});
      fail_inject <= 1'b1;
      axw(8'h04, 32'(a + 8'h01), 2'h0);
      op(3'h1);
      chk(32'h0000_0004, 32'h0000_0004);
      fail_inject <= 1'b0;
      op(3'h4);
      axw(8'h04, 32'(a), 2'h0);
      axw(8'h00, 32'h0000_0002, 2'h0);
      repeat (2000) @(posedge clk);
      chk(32'h0000_0001, 32'h0000_0001);
      wait_idle();
      chk(32'h0000_0007, 32'h0000_0002);
      op(3'h0);
      chk(32'h0000_ff00, 32'h0000_ff00);
      axw(8'h10, 32'h0000_0000, 2'h2);
      axr(8'h10, '1, {2'h2, 32'h0000_0000}, s);
      summarize();
   end
endmodule : tb_top
